// ===== line_framer_regs.sv
// line status, interrupt enable, master mode and ds1 receive configuration registers
//
// Behaviour
// - open-circuit indication falling sets latched status bit 6.
// - short-circuit indication falling sets latched status bit 5.
// - loss-of-signal indication falling sets latched status bit 4.
// - open-circuit indication rising sets latched status bit 2.
// - short-circuit indication rising sets latched status bit 1.
// - loss-of-signal indication rising sets latched status bit 0.
// - latched bits clear only on a written one; zero leaves them alone.
// - interrupt asserts while any latched bit and its enable are both set.
// - enable register mirrors status bit positions; one enables, zero masks.
// - receive framer stays disabled, low power, while receive enable is zero.
// - receiver enables once init-done is set, receive enable is one and receive soft reset is zero.
// - receive framer held in reset while receive soft reset bit is one.
// - receive mode select zero means T1, one means E1, independent of transmit.
// - transmit formatter stays disabled, low power, while transmit enable is zero.
// - transmitter enables once init-done is set, transmit enable is one and transmit soft reset is zero.
// - transmit formatter held in reset while transmit soft reset bit is one.
// - transmit mode select zero means T1, one means E1, independent of receive.
// - sync needs 10 framing bits when sync time is zero, 24 when one.
// - receive zero-substitution decoding on when its bit is one.
// - frame format bit zero selects extended superframe, one selects D4.
// - auto-resync on out-of-frame or loss when zero, out-of-frame only when one.
// - real-time loss indication is high while the line receiver sees loss.
// - each zero-to-one write of the resync bit starts a new frame search.
`timescale 1ns/1ps
`include "bits_regs.svh"

module line_framer_regs (
	input  wire logic       clock_i,           // system clock, 40 MHz
	input  wire logic       rstn_i,            // async reset, active low
	// host register port
	input  wire logic [7:0] addr_i,            // register offset
	input  wire logic [7:0] wdata_i,           // write data
	input  wire logic       wr_i,              // write strobe, one cycle
	input  wire logic       rd_i,              // read strobe, one cycle
	output logic      [7:0] rdata_o,           // read data, valid cycle after rd_i
	output logic            interrupt_request_out_o, // interrupt request, active high
	// real-time line indications from the analog interface
	input  wire logic       tx_open_i,         // transmit open circuit
	input  wire logic       tx_short_i,        // transmit short circuit
	input  wire logic       rx_loss_i,         // receive loss of signal
	output logic            rx_loss_rt_o,      // synchronised loss of signal
	// receive framer control
	output logic            rx_enable_o,       // framer running
	output logic            rx_reset_o,        // framer held in reset
	output logic            rx_e1_o,           // 0 T1, 1 E1
	output logic      [4:0] sync_bits_o,       // framing bits to qualify
	output logic            zero_sub_decode_o, // zero-substitution decoding on
	output logic            frame_sf_o,        // 0 extended superframe, 1 D4
	output logic            resync_on_loss_o,  // loss of signal also triggers resync
	output logic            sync_criteria_o,   // sync criteria select
	output logic            japan_crc_o,       // alternate crc-6 calculation
	output logic            sync_disable_o,    // automatic resync disabled
	output logic            resync_pulse_o,    // one-cycle new frame search
	// transmit formatter control
	output logic            tx_enable_o,       // formatter running
	output logic            tx_reset_o,        // formatter held in reset
	output logic            tx_e1_o            // 0 T1, 1 E1
);

	// header constants the logic relies on; refused at elaboration if they drift
	if (bits_pkg::LINE_W != 3) begin : g_line_check
		$error("line_framer_regs: three line indications are wired, LINE_W must be 3");
	end
	if (`SYNC_BITS_LONG <= `SYNC_BITS_SHORT) begin : g_sync_check
		$error("line_framer_regs: long sync count must exceed the short one");
	end
	if (`LAT_STATUS_MASK != `INT_ENABLE_MASK) begin : g_enable_mask_check
		$error("line_framer_regs: enable bits must mirror the latched status bits");
	end
	if (`RT_INFO_MASK != 8'h07) begin : g_info_mask_check
		$error("line_framer_regs: real-time information holds three bits");
	end
	if (`DS1_RX_CFG_MASK != 8'hFF) begin : g_cfg_mask_check
		$error("line_framer_regs: every configuration bit is implemented");
	end

	// every latched event bit must be an implemented status bit
	if (((8'h01 << `OPEN_CLEARED_BIT) | (8'h01 << `SHORT_CLEARED_BIT)
		| (8'h01 << `LOSS_CLEARED_BIT) | (8'h01 << `OPEN_DETECT_BIT)
		| (8'h01 << `SHORT_DETECT_BIT) | (8'h01 << `LOSS_DETECT_BIT))
		!= `LAT_STATUS_MASK) begin : g_event_bits_check
		$error("line_framer_regs: event bit positions disagree with the status mask");
	end

	// the mode mask holds exactly the four mode fields
	if (((8'h01 << `MODE_ENABLE_BIT) | (8'h01 << `MODE_INIT_DONE_BIT)
		| (8'h01 << `MODE_SOFT_RESET_BIT) | (8'h01 << `MODE_SELECT_BIT))
		!= `MODE_MASK) begin : g_mode_bits_check
		$error("line_framer_regs: mode field positions disagree with the mode mask");
	end

	bits_pkg::bank_s st_r;
	bits_pkg::bank_s st_nxt;

	// synchronised levels and one-cycle edge pulses of the line indications
	logic [2:0] rt_level;
	logic [2:0] rt_rise;
	logic [2:0] rt_fall;

	// masked write of a read/write register
	function automatic logic [7:0] masked(input logic [7:0] value, input logic [7:0] mask);
		masked = value & mask;
	endfunction : masked

	// enabled only after init-done, with enable set and out of reset
	function automatic logic unit_running(input logic [7:0] mode);
		unit_running = mode[`MODE_ENABLE_BIT] & mode[`MODE_INIT_DONE_BIT]
			& ~mode[`MODE_SOFT_RESET_BIT];
	endfunction : unit_running

	// soft reset level of a master mode register
	function automatic logic unit_held(input logic [7:0] mode);
		unit_held = mode[`MODE_SOFT_RESET_BIT];
	endfunction : unit_held

	// line standard of a master mode register: 0 T1, 1 E1
	function automatic logic unit_e1(input logic [7:0] mode);
		unit_e1 = mode[`MODE_SELECT_BIT];
	endfunction : unit_e1

	// synchronise the three line indications and find their edges
	line_edge_detect #(
		.WIDTH (bits_pkg::LINE_W)
	) u_edges (
		.clock_i (clock_i),
		.rstn_i  (rstn_i),
		.line_i  ({tx_open_i, tx_short_i, rx_loss_i}),
		.level_o (rt_level),
		.rise_o  (rt_rise),
		.fall_o  (rt_fall)
	);

	// next-state logic of the whole bank
	always_comb begin
		logic [7:0] set_mask;
		logic [7:0] clr_mask;
		logic [7:0] rx_cfg_new;
		logic       wr_status;
		logic [7:0] pending;
		set_mask   = 8'h00;
		pending    = 8'h00;
		clr_mask   = 8'h00;
		rx_cfg_new = st_r.rx_cfg;
		wr_status  = wr_i && (addr_i == `LAT_STATUS_OFFSET);
		st_nxt     = st_r;

		// edge events onto latched bits
		set_mask[`OPEN_CLEARED_BIT]  = rt_fall[`RT_OPEN_BIT];
		set_mask[`SHORT_CLEARED_BIT] = rt_fall[`RT_SHORT_BIT];
		set_mask[`LOSS_CLEARED_BIT]  = rt_fall[`RT_LOSS_BIT];
		set_mask[`OPEN_DETECT_BIT]   = rt_rise[`RT_OPEN_BIT];
		set_mask[`SHORT_DETECT_BIT]  = rt_rise[`RT_SHORT_BIT];
		set_mask[`LOSS_DETECT_BIT]   = rt_rise[`RT_LOSS_BIT];

		// write-one-to-clear; a new event in the same cycle wins
		if (wr_status) begin
			clr_mask = wdata_i;
		end
		st_nxt.lat_status = masked((st_r.lat_status & ~clr_mask) | set_mask,
			`LAT_STATUS_MASK);

		// read/write registers
		if (wr_i) begin
			unique case (addr_i)
				`INT_ENABLE_OFFSET: begin
					st_nxt.int_enable = masked(wdata_i, `INT_ENABLE_MASK);
				end
				`RX_MODE_OFFSET: begin
					st_nxt.rx_mode = masked(wdata_i, `MODE_MASK);
				end
				`TX_MODE_OFFSET: begin
					st_nxt.tx_mode = masked(wdata_i, `MODE_MASK);
				end
				`DS1_RX_CFG_OFFSET: begin
					// taken in either mode; keeping out in E1 mode is up to software
					rx_cfg_new    = masked(wdata_i, `DS1_RX_CFG_MASK);
					st_nxt.rx_cfg = rx_cfg_new;
				end
				default: begin
				end
			endcase
		end

		// pending sources from next values, so the interrupt rises with
		// the flag and drops on the write that clears or masks the last one
		pending    = st_nxt.lat_status & st_nxt.int_enable;
		st_nxt.irq = |pending;

		// receive framer control from next register values
		st_nxt.rx_enable = unit_running(st_nxt.rx_mode);
		st_nxt.rx_reset  = unit_held(st_nxt.rx_mode);
		st_nxt.rx_e1     = unit_e1(st_nxt.rx_mode);

		// transmit formatter control
		st_nxt.tx_enable = unit_running(st_nxt.tx_mode);
		st_nxt.tx_reset  = unit_held(st_nxt.tx_mode);
		st_nxt.tx_e1     = unit_e1(st_nxt.tx_mode);

		// ds1 framer configuration
		st_nxt.sync_bits = st_nxt.rx_cfg[`CFG_SYNC_TIME_BIT] ?
			`SYNC_BITS_LONG : `SYNC_BITS_SHORT;
		st_nxt.zero_sub_decode = st_nxt.rx_cfg[`CFG_ZERO_SUB_BIT];
		st_nxt.frame_sf        = st_nxt.rx_cfg[`CFG_FRAME_FMT_BIT];
		st_nxt.resync_on_loss  = ~st_nxt.rx_cfg[`CFG_AUTO_RESYNC_BIT];
		st_nxt.sync_criteria   = st_nxt.rx_cfg[`CFG_SYNC_CRIT_BIT];
		st_nxt.japan_crc       = st_nxt.rx_cfg[`CFG_JAPAN_CRC_BIT];
		st_nxt.sync_disable    = st_nxt.rx_cfg[`CFG_SYNC_DIS_BIT];

		// zero-to-one of the resync bit starts one frame search
		st_nxt.resync_pulse = rx_cfg_new[`CFG_RESYNC_BIT]
			& ~st_r.rx_cfg[`CFG_RESYNC_BIT];

		// read data captured on the read strobe, held otherwise
		if (rd_i) begin
			unique case (addr_i)
				`RT_INFO_OFFSET:    st_nxt.rdata = masked({5'h00, rt_level},
					`RT_INFO_MASK);
				`LAT_STATUS_OFFSET: st_nxt.rdata = st_r.lat_status;
				`INT_ENABLE_OFFSET: st_nxt.rdata = st_r.int_enable;
				`RX_MODE_OFFSET:    st_nxt.rdata = st_r.rx_mode;
				`TX_MODE_OFFSET:    st_nxt.rdata = st_r.tx_mode;
				`DS1_RX_CFG_OFFSET: st_nxt.rdata = st_r.rx_cfg;
				default:            st_nxt.rdata = 8'h00;
			endcase
		end
	end

	// bank state register
	always_ff @(posedge clock_i or negedge rstn_i) begin
		if (!rstn_i) begin
			// register fields
			st_r.lat_status      <= `LAT_STATUS_RESET;
			st_r.int_enable      <= `INT_ENABLE_RESET;
			st_r.rx_mode         <= `RX_MODE_RESET;
			st_r.tx_mode         <= `TX_MODE_RESET;
			st_r.rx_cfg          <= `DS1_RX_CFG_RESET;
			st_r.rdata           <= 8'h00;
			// controls as the reset register values decode them
			st_r.irq             <= 1'b0;
			st_r.rx_enable       <= 1'b0;
			st_r.rx_reset        <= 1'b0;
			st_r.rx_e1           <= 1'b0;
			st_r.tx_enable       <= 1'b0;
			st_r.tx_reset        <= 1'b0;
			st_r.tx_e1           <= 1'b0;
			st_r.sync_bits       <= `SYNC_BITS_SHORT;
			st_r.zero_sub_decode <= 1'b0;
			st_r.frame_sf        <= 1'b0;
			st_r.resync_on_loss  <= 1'b1;
			st_r.sync_criteria   <= 1'b0;
			st_r.japan_crc       <= 1'b0;
			st_r.sync_disable    <= 1'b0;
			st_r.resync_pulse    <= 1'b0;
		end else begin
			st_r <= st_nxt;
		end
	end

	// real-time loss flop, fed from the edge detector's synchronised level
	logic rx_loss_rt_r;

	// registered copy so the output comes from its own flop
	always_ff @(posedge clock_i or negedge rstn_i) begin
		if (!rstn_i) begin
			rx_loss_rt_r <= 1'b0;
		end else begin
			rx_loss_rt_r <= rt_level[`RT_LOSS_BIT];
		end
	end

	// register port and interrupt, straight from flops
	assign rdata_o                 = st_r.rdata;
	assign interrupt_request_out_o = st_r.irq;
	assign rx_loss_rt_o            = rx_loss_rt_r;

	// receive framer controls
	assign rx_enable_o             = st_r.rx_enable;
	assign rx_reset_o              = st_r.rx_reset;
	assign rx_e1_o                 = st_r.rx_e1;

	// ds1 framer configuration
	assign sync_bits_o             = st_r.sync_bits;
	assign zero_sub_decode_o       = st_r.zero_sub_decode;
	assign frame_sf_o              = st_r.frame_sf;
	assign resync_on_loss_o        = st_r.resync_on_loss;
	assign sync_criteria_o         = st_r.sync_criteria;
	assign japan_crc_o             = st_r.japan_crc;
	assign sync_disable_o          = st_r.sync_disable;
	assign resync_pulse_o          = st_r.resync_pulse;

	// transmit formatter controls
	assign tx_enable_o             = st_r.tx_enable;
	assign tx_reset_o              = st_r.tx_reset;
	assign tx_e1_o                 = st_r.tx_e1;

endmodule : line_framer_regs

// ===== bits_regs.svh
// register offsets, field positions, masks and reset values of the line/framer registers
`ifndef BITS_REGS_SVH
`define BITS_REGS_SVH

// register offsets on the host register port
`define RT_INFO_OFFSET      8'h18
`define LAT_STATUS_OFFSET   8'h1A
`define INT_ENABLE_OFFSET   8'h1B
`define RX_MODE_OFFSET      8'h20
`define TX_MODE_OFFSET      8'h21
`define DS1_RX_CFG_OFFSET   8'h22

// reset values
`define LAT_STATUS_RESET    8'h00
`define INT_ENABLE_RESET    8'h00
`define RX_MODE_RESET       8'h00
`define TX_MODE_RESET       8'h00
`define DS1_RX_CFG_RESET    8'h00

// implemented bits; reserved bits read as zero
`define LAT_STATUS_MASK     8'h77
`define INT_ENABLE_MASK     8'h77
`define MODE_MASK           8'hC3
`define DS1_RX_CFG_MASK     8'hFF
`define RT_INFO_MASK        8'h07

// latched status and enable bit positions
`define OPEN_CLEARED_BIT    6
`define SHORT_CLEARED_BIT   5
`define LOSS_CLEARED_BIT    4
`define OPEN_DETECT_BIT     2
`define SHORT_DETECT_BIT    1
`define LOSS_DETECT_BIT     0

// real-time line information bit positions
`define RT_OPEN_BIT         2
`define RT_SHORT_BIT        1
`define RT_LOSS_BIT         0

// master mode register fields (receive and transmit alike)
`define MODE_ENABLE_BIT     7
`define MODE_INIT_DONE_BIT  6
`define MODE_SOFT_RESET_BIT 1
`define MODE_SELECT_BIT     0

// ds1 receive configuration fields
`define CFG_SYNC_TIME_BIT   7
`define CFG_ZERO_SUB_BIT    6
`define CFG_FRAME_FMT_BIT   5
`define CFG_AUTO_RESYNC_BIT 4
`define CFG_SYNC_CRIT_BIT   3
`define CFG_JAPAN_CRC_BIT   2
`define CFG_SYNC_DIS_BIT    1
`define CFG_RESYNC_BIT      0

// framing bits to qualify before sync is declared
`define SYNC_BITS_SHORT     5'd10
`define SYNC_BITS_LONG      5'd24

`endif

// ===== bits_pkg.sv
// types shared by the line status and framer mode register logic
package bits_pkg;

	// number of real-time line indications watched for edges
	parameter int LINE_W = 3;

	// state of the indication synchroniser and edge detector
	typedef struct packed {
		logic [LINE_W-1:0] meta;   // first synchroniser stage
		logic [LINE_W-1:0] level;  // second synchroniser stage
		logic [LINE_W-1:0] prev;   // level one cycle earlier
		logic [LINE_W-1:0] rise;   // low-to-high pulse
		logic [LINE_W-1:0] fall;   // high-to-low pulse
	} line_edge_s;

	// state of the register bank
	typedef struct packed {
		logic [7:0] lat_status;    // line_latched_status
		logic [7:0] int_enable;    // line_interrupt_enable
		logic [7:0] rx_mode;       // receive_master_mode
		logic [7:0] tx_mode;       // transmit_master_mode
		logic [7:0] rx_cfg;        // ds1_receive_config
		logic [7:0] rdata;         // read data holding register
		logic       irq;           // interrupt_request_out
		logic       rx_enable;
		logic       rx_reset;
		logic       rx_e1;
		logic       tx_enable;
		logic       tx_reset;
		logic       tx_e1;
		logic [4:0] sync_bits;
		logic       zero_sub_decode;
		logic       frame_sf;
		logic       resync_on_loss;
		logic       sync_criteria;
		logic       japan_crc;
		logic       sync_disable;
		logic       resync_pulse;
	} bank_s;

endpackage : bits_pkg

// ===== line_edge_detect.sv
// synchroniser and edge detector for the real-time line indications
`timescale 1ns/1ps
`include "bits_regs.svh"

module line_edge_detect #(
	parameter int WIDTH = bits_pkg::LINE_W
) (
	input  wire logic             clock_i,  // system clock
	input  wire logic             rstn_i,   // async reset, active low
	input  wire logic [WIDTH-1:0] line_i,   // raw indications from the line interface
	output logic      [WIDTH-1:0] level_o,  // synchronised level
	output logic      [WIDTH-1:0] rise_o,   // one-cycle low-to-high pulse
	output logic      [WIDTH-1:0] fall_o    // one-cycle high-to-low pulse
);

	// the struct is sized by the package, so the width cannot float
	if (WIDTH != bits_pkg::LINE_W) begin : g_width_check
		$error("line_edge_detect: WIDTH must equal bits_pkg::LINE_W");
	end

	bits_pkg::line_edge_s st_r;
	bits_pkg::line_edge_s st_nxt;

	// first stage feeds only the second; edges taken from synced level
	always_comb begin
		st_nxt       = st_r;
		st_nxt.meta  = line_i;
		st_nxt.level = st_r.meta;
		st_nxt.prev  = st_r.level;
		st_nxt.rise  = st_r.level & ~st_r.prev;
		st_nxt.fall  = ~st_r.level & st_r.prev;
	end

	// state register
	always_ff @(posedge clock_i or negedge rstn_i) begin
		if (!rstn_i) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign level_o = st_r.level;
	assign rise_o  = st_r.rise;
	assign fall_o  = st_r.fall;

endmodule : line_edge_detect

// ===== line_framer_regs_chk.sv
// concurrent checks on the line status and framer mode register ports
`timescale 1ns/1ps

module line_framer_regs_chk (
	input wire logic       clock_i,                 // system clock
	input wire logic       rstn_i,                  // async reset, active low
	input wire logic [7:0] addr_i,                  // register offset
	input wire logic [7:0] wdata_i,                 // write data
	input wire logic       wr_i,                    // write strobe
	input wire logic       interrupt_request_out_o, // interrupt request
	input wire logic       rx_loss_i,               // raw loss of signal
	input wire logic       rx_loss_rt_o,            // synchronised loss
	input wire logic       rx_enable_o,             // framer running
	input wire logic       rx_reset_o,              // framer in reset
	input wire logic       rx_e1_o,                 // receive mode
	input wire logic [4:0] sync_bits_o,             // framing bits to qualify
	input wire logic       zero_sub_decode_o,       // decoding on
	input wire logic       frame_sf_o,              // frame format
	input wire logic       resync_on_loss_o,        // loss triggers resync
	input wire logic       resync_pulse_o,          // new frame search
	input wire logic       tx_enable_o,             // formatter running
	input wire logic       tx_reset_o,              // formatter in reset
	input wire logic       tx_e1_o                  // transmit mode
);
	default clocking cb @(posedge clock_i); endclocking
	default disable iff (!rstn_i);

	// soft reset gates the enables
	property p_rx_gate;
		rx_enable_o |-> !rx_reset_o;
	endproperty
	a_rx_gate: assert property (p_rx_gate)
		else $error("receive framer enabled while held in reset");
	property p_tx_gate;
		tx_enable_o |-> !tx_reset_o;
	endproperty
	a_tx_gate: assert property (p_tx_gate)
		else $error("transmit formatter enabled while held in reset");
	// mode register writes reach the controls one cycle later
	property p_rx_mode;
		wr_i && addr_i == 8'h20 |=> rx_e1_o == $past(wdata_i[0]) && rx_reset_o == $past(wdata_i[1])
			&& rx_enable_o == $past(wdata_i[7] & wdata_i[6] & ~wdata_i[1]);
	endproperty
	a_rx_mode: assert property (p_rx_mode)
		else $error("receive controls do not follow mode write");
	property p_tx_mode;
		wr_i && addr_i == 8'h21 |=> tx_e1_o == $past(wdata_i[0]) && tx_reset_o == $past(wdata_i[1])
			&& tx_enable_o == $past(wdata_i[7] & wdata_i[6] & ~wdata_i[1]);
	endproperty
	a_tx_mode: assert property (p_tx_mode)
		else $error("transmit controls do not follow mode write");
	property p_cfg;
		wr_i && addr_i == 8'h22 |=> sync_bits_o == ($past(wdata_i[7]) ? 5'h18 : 5'h0A)
			&& zero_sub_decode_o == $past(wdata_i[6]) && frame_sf_o == $past(wdata_i[5])
			&& resync_on_loss_o == !$past(wdata_i[4]);
	endproperty
	a_cfg: assert property (p_cfg)
		else $error("framer configuration does not follow write");
	property p_sync_range;
		sync_bits_o == 5'h0A || sync_bits_o == 5'h18;
	endproperty
	a_sync_range: assert property (p_sync_range)
		else $error("sync bit count out of range");
	// resync pulse only after a write of bit 0, one cycle wide
	property p_resync_cause;
		resync_pulse_o |-> $past(wr_i && addr_i == 8'h22 && wdata_i[0]);
	endproperty
	a_resync_cause: assert property (p_resync_cause)
		else $error("resync pulse without a resync write");
	property p_resync_once;
		resync_pulse_o |=> !resync_pulse_o;
	endproperty
	a_resync_once: assert property (p_resync_once)
		else $error("resync pulse wider than one cycle");
	property p_loss_rt;
		$stable(rx_loss_i) [*5] |-> rx_loss_rt_o == rx_loss_i;
	endproperty
	a_loss_rt: assert property (p_loss_rt)
		else $error("loss indication does not follow the line");
	property p_irq_mask;
		wr_i && addr_i == 8'h1B && wdata_i == 8'h00 |=> !interrupt_request_out_o;
	endproperty
	a_irq_mask: assert property (p_irq_mask)
		else $error("interrupt stays up with all sources masked");
endmodule : line_framer_regs_chk

bind line_framer_regs line_framer_regs_chk line_framer_regs_chk_inst (
	.clock_i(clock_i), .rstn_i(rstn_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
	.interrupt_request_out_o(interrupt_request_out_o), .rx_loss_i(rx_loss_i),
	.rx_loss_rt_o(rx_loss_rt_o), .rx_enable_o(rx_enable_o), .rx_reset_o(rx_reset_o),
	.rx_e1_o(rx_e1_o), .sync_bits_o(sync_bits_o), .zero_sub_decode_o(zero_sub_decode_o),
	.frame_sf_o(frame_sf_o), .resync_on_loss_o(resync_on_loss_o),
	.resync_pulse_o(resync_pulse_o), .tx_enable_o(tx_enable_o), .tx_reset_o(tx_reset_o),
	.tx_e1_o(tx_e1_o));

// ===== tb_top.sv
// self-checking bench for the line status and framer mode registers
`timescale 1ns/1ps

module tb_top;
	logic       clock_i, rstn_i, wr_i, rd_i, irq, rx_loss_rt_o, rx_enable_o, rx_reset_o;
	logic       rx_e1_o, zsd, fsf, rol, scr, jcrc, sdis, rsp, tx_enable_o, tx_reset_o, tx_e1_o;
	logic [7:0] addr_i, wdata_i, rdata_o, lat, ien, rxm, txm, cfg, d;
	logic [4:0] sync_bits_o;
	logic [2:0] ln;  // open, short, loss
	int         bad_count, n_checks, i, k;
	logic [7:0] ra [7] = '{8'h1A, 8'h1B, 8'h20, 8'h21, 8'h22, 8'h18, 8'h30};
	logic [7:0] mv [6] = '{8'h81, 8'hC1, 8'hC3, 8'hC1, 8'h41, 8'h00};

	line_framer_regs line_framer_regs_inst (
		.clock_i(clock_i), .rstn_i(rstn_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
		.rd_i(rd_i), .rdata_o(rdata_o), .interrupt_request_out_o(irq), .tx_open_i(ln[2]),
		.tx_short_i(ln[1]), .rx_loss_i(ln[0]), .rx_loss_rt_o(rx_loss_rt_o),
		.rx_enable_o(rx_enable_o), .rx_reset_o(rx_reset_o), .rx_e1_o(rx_e1_o),
		.sync_bits_o(sync_bits_o), .zero_sub_decode_o(zsd), .frame_sf_o(fsf),
		.resync_on_loss_o(rol), .sync_criteria_o(scr), .japan_crc_o(jcrc),
		.sync_disable_o(sdis), .resync_pulse_o(rsp), .tx_enable_o(tx_enable_o),
		.tx_reset_o(tx_reset_o), .tx_e1_o(tx_e1_o));

	// 40 MHz clock
	initial begin
		clock_i = 1'b0;
		forever #12.5 clock_i = ~clock_i;
	end

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	task automatic chk_outs;
		chk(irq, |(lat & ien));
		chk(rx_loss_rt_o, ln[0]);
		chk({rx_enable_o, rx_reset_o, rx_e1_o}, {rxm[7] & rxm[6] & ~rxm[1], rxm[1:0]});
		chk({tx_enable_o, tx_reset_o, tx_e1_o}, {txm[7] & txm[6] & ~txm[1], txm[1:0]});
		chk(sync_bits_o, cfg[7] ? 8'h18 : 8'h0A);
		chk({zsd, fsf, rol, scr, jcrc, sdis}, {cfg[6:5], ~cfg[4], cfg[3:1]});
	endtask : chk_outs

	// one write cycle, then model update and output compare
	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		@(negedge clock_i);
		addr_i = a;
		wdata_i = v;
		wr_i = 1'b1;
		@(negedge clock_i);
		wr_i = 1'b0;
		chk(rsp, a == 8'h22 && v[0] && !cfg[0]);
		case (a)
			8'h1A: lat = lat & ~v;
			8'h1B: ien = v & 8'h77;
			8'h20: rxm = v & 8'hC3;
			8'h21: txm = v & 8'hC3;
			8'h22: cfg = v;
			default: ;
		endcase
		chk_outs();
	endtask : wr

	task automatic rd(input logic [7:0] a);
		@(negedge clock_i);
		addr_i = a;
		rd_i = 1'b1;
		@(negedge clock_i);
		rd_i = 1'b0;
		case (a)
			8'h1A: chk(rdata_o, lat);
			8'h1B: chk(rdata_o, ien);
			8'h20: chk(rdata_o, rxm);
			8'h21: chk(rdata_o, txm);
			8'h22: chk(rdata_o, cfg);
			8'h18: chk(rdata_o, {5'h00, ln});
			default: chk(rdata_o, 8'h00);
		endcase
	endtask : rd

	// move one line indication and let the sync chain settle
	task automatic line(input int b, input logic v);
		@(negedge clock_i);
		ln[b] = v;
		lat[v ? b : b + 4] = 1'b1;
		repeat (6) @(negedge clock_i);
		chk_outs();
		rd(8'h1A);
	endtask : line

	task automatic results;
		$display("checks %0d mismatches %0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : results

	// watchdog against a hung run
	initial begin
		#1ms;
		bad_count++;
		results();
	end

	// main sequence
	initial begin
		{bad_count, n_checks, ln, addr_i, wdata_i, wr_i, rd_i} = '0;
		{lat, ien, rxm, txm, cfg} = '0;
		rstn_i = 1'b0;
		void'($urandom(2));
		repeat (6) @(negedge clock_i);
		rstn_i = 1'b1;
		foreach (ra[i]) rd(ra[i]);
		chk_outs();
		$display("test reset values done");
		for (i = 0; i < 40; i++) begin
			k = $urandom % 7;
			d = $urandom;
			if (k == 4 && rxm[0]) k = 5; // config register left alone in E1 mode
			wr(ra[k], d);
			rd(ra[k]);
		end
		$display("test random access done");
		wr(8'h1B, 8'h77);
		for (k = 0; k < 3; k++) begin
			line(k, 1'b1);
			line(k, 1'b0);
		end
		wr(8'h1A, 8'h00);
		rd(8'h1A);
		wr(8'h1B, 8'h01);
		wr(8'h1B, 8'h00);
		wr(8'h1B, 8'h77);
		for (k = 0; k < 7; k++) wr(8'h1A, 8'h01 << k);
		rd(8'h1A);
		$display("test line events done");
		foreach (mv[i]) begin
			wr(8'h20, mv[i]);
			wr(8'h21, mv[i] ^ 8'h01);
		end
		for (k = 0; k < 4; k++) wr(8'h22, {k[1], 6'h00, k[0]});
		wr(8'h22, 8'h01);
		$display("test modes done");
		@(negedge clock_i);
		rstn_i = 1'b0;
		repeat (2) @(negedge clock_i);
		rstn_i = 1'b1;
		{lat, ien, rxm, txm, cfg} = '0;
		foreach (ra[i]) rd(ra[i]);
		chk_outs();
		$display("test second reset done");
		results();
	end
endmodule : tb_top
